/* File: rtl/eeb_slave.v */
// Two-wire bus slave front end of a 16 Kbit serial EEPROM.
// Assumes scl_i/sda_i come straight from pins; sda is open drain, so the
// pad pulls low while sda_oe_o is high and sda_o is low.
`timescale 1ns/1ns
`include "eeb_consts.vh"

// Summary of operation
// - The first byte after a start is type (4 bits), block select (3 bits), then R/W as LSB.
// - The device acknowledges only when the received type field equals its own type code.
// - The 3-bit block select picks one of 8 page blocks of 256 bytes each.
// - R/W bit 1 means read from the device, 0 means write to it.
// - A receiver pulls data low through the 9th clock of each byte, then lets go.
// - A transmitter releases data after 8 bits and samples the acknowledge on the 9th clock.
// - The receiving party acknowledges every byte unless it wants to end the transfer.
// - The byte after a write-direction slave address is the 8-bit array address.
// - A page is 16 bytes on a 16-byte boundary, programmed in one write cycle.
// - After a stop ends a write, a self-timed program cycle of 10 ms or 15 ms runs.
// - During the program cycle the bus is ignored, data stays released, no acknowledge.
// - Clock and data pulses narrower than 100 ns, or 50 ns in fast grade, are ignored.
// - With no chip-select pins every block select code 000 to 111 selects this device.
// - In read mode a missing master acknowledge stops sending until the next start or stop.
module eeb_slave #(
  parameter FAST_GRADE = 0,
  parameter LOW_SUPPLY = 0,
  parameter TWR_CYCLES = LOW_SUPPLY ? `EEB_TWR_LO_CYC : `EEB_TWR_HI_CYC,
  // Arbitrary type code; set it to the code the bus master addresses
  parameter [3:0] TYPE_CODE = 4'h6
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  output reg write_busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants

  localparam FILT_CYCLES = FAST_GRADE ? `EEB_NOISE_FAST_CYC : `EEB_NOISE_STD_CYC;
  localparam integer TWR_LAST_I = TWR_CYCLES - 1;
  localparam integer BYTE_BITS_I = `EEB_BITS_PER_BYTE;
  localparam integer PAGE_LAST_I = `EEB_PAGE_BYTES - 1;
  localparam [`EEB_TWR_CNT_W-1:0] TWR_LAST = TWR_LAST_I[`EEB_TWR_CNT_W-1:0];
  localparam [3:0] BYTE_BITS = BYTE_BITS_I[3:0];
  localparam [`EEB_PAGE_IDX_W-1:0] PAGE_LAST = PAGE_LAST_I[`EEB_PAGE_IDX_W-1:0];

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RX = 3'd1;
  localparam [2:0] ST_ACK = 3'd2;
  localparam [2:0] ST_TX = 3'd3;
  localparam [2:0] ST_RACK = 3'd4;
  localparam [2:0] ST_WAIT = 3'd5;
  localparam [2:0] ST_COMMIT = 3'd6;
  localparam [2:0] ST_TWR = 3'd7;

  localparam [1:0] KIND_SLAVE = 2'd0;
  localparam [1:0] KIND_ADDR = 2'd1;
  localparam [1:0] KIND_DATA = 2'd2;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  wire scl_f;
  wire sda_f;
  reg scl_d_reg;
  reg sda_d_reg;
  reg [2:0] state_reg;
  reg [1:0] kind_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] tx_shift_reg;
  reg rw_reg;
  reg write_mode_reg;
  reg [2:0] blk_reg;
  reg [`EEB_ADDR_W-1:0] addr_reg;
  reg [`EEB_ADDR_W-`EEB_PAGE_IDX_W-1:0] page_base_reg;
  reg [`EEB_PAGE_BYTES-1:0] mask_reg;
  reg [`EEB_PAGE_IDX_W-1:0] commit_idx_reg;
  reg [`EEB_TWR_CNT_W-1:0] twr_cnt_reg;
  reg mem_we_reg;
  reg [`EEB_ADDR_W-1:0] mem_waddr_reg;
  reg [7:0] mem_wdata_reg;
  wire [7:0] mem_rdata;
  reg [7:0] page_buf [0:`EEB_PAGE_BYTES-1];

  wire scl_rise = scl_f & ~scl_d_reg;
  wire scl_fall = ~scl_f & scl_d_reg;
  wire start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  wire stop_det = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  wire bus_busy = (state_reg == ST_COMMIT) || (state_reg == ST_TWR);
  wire byte_done = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == BYTE_BITS);

  wire [3:0] type_field = rx_shift_reg[`EEB_SA_TYPE_MSB:`EEB_SA_TYPE_LSB];
  wire block_select_bit2 = rx_shift_reg[`EEB_SA_BLK_MSB];
  wire block_select_bit1 = rx_shift_reg[`EEB_SA_BLK_LSB+1];
  wire block_select_bit0 = rx_shift_reg[`EEB_SA_BLK_LSB];
  wire rw_bit = rx_shift_reg[`EEB_SA_RW_BIT];
  wire [`EEB_PAGE_IDX_W-1:0] page_idx = addr_reg[`EEB_PAGE_IDX_W-1:0];
  wire buf_we = byte_done && (kind_reg == KIND_DATA) && !start_det && !stop_det;

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning and storage

  eeb_pin_filter #(.STABLE_CYCLES(FILT_CYCLES), .CW(8)) u_scl_filt (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(scl_i),
    .level_o(scl_f)
  );

  eeb_pin_filter #(.STABLE_CYCLES(FILT_CYCLES), .CW(8)) u_sda_filt (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sda_i),
    .level_o(sda_f)
  );

  eeb_mem #(.AW(`EEB_ADDR_W), .DW(8)) u_mem (
    .mclk_i(mclk_i),
    .we_i(mem_we_reg),
    .waddr_i(mem_waddr_reg),
    .wdata_i(mem_wdata_reg),
    .raddr_i(addr_reg),
    .rdata_o(mem_rdata)
  );

  // Page buffer holds data until the stop; the mask says which bytes to program
  always @(posedge mclk_i)
  begin
    if (buf_we)
      page_buf[page_idx] <= rx_shift_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine

  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      kind_reg <= KIND_SLAVE;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      write_mode_reg <= 1'b0;
      blk_reg <= 3'h0;
      addr_reg <= {`EEB_ADDR_W{1'b0}};
      page_base_reg <= {(`EEB_ADDR_W-`EEB_PAGE_IDX_W){1'b0}};
      mask_reg <= {`EEB_PAGE_BYTES{1'b0}};
      commit_idx_reg <= {`EEB_PAGE_IDX_W{1'b0}};
      twr_cnt_reg <= {`EEB_TWR_CNT_W{1'b0}};
      mem_we_reg <= 1'b0;
      mem_waddr_reg <= {`EEB_ADDR_W{1'b0}};
      mem_wdata_reg <= 8'h00;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      write_busy_o <= 1'b0;
    end
    else
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      mem_we_reg <= 1'b0;
      sda_o <= 1'b0;
      if (state_reg == ST_COMMIT)
      begin
        // Bus fully ignored while programming; data line stays released
        sda_oe_o <= 1'b0;
        if (mask_reg[commit_idx_reg])
        begin
          mem_we_reg <= 1'b1;
          mem_waddr_reg <= {page_base_reg, commit_idx_reg};
          mem_wdata_reg <= page_buf[commit_idx_reg];
        end
        commit_idx_reg <= commit_idx_reg + 1'b1;
        if (commit_idx_reg == PAGE_LAST)
        begin
          state_reg <= ST_TWR;
          twr_cnt_reg <= {`EEB_TWR_CNT_W{1'b0}};
        end
      end
      else if (state_reg == ST_TWR)
      begin
        sda_oe_o <= 1'b0;
        twr_cnt_reg <= twr_cnt_reg + 1'b1;
        if (twr_cnt_reg == TWR_LAST)
        begin
          state_reg <= ST_IDLE;
          write_busy_o <= 1'b0;
          mask_reg <= {`EEB_PAGE_BYTES{1'b0}};
        end
      end
      else if (start_det)
      begin
        // A start, repeated or not, restarts slave address capture unless a program cycle is running
        state_reg <= ST_RX;
        kind_reg <= KIND_SLAVE;
        bit_cnt_reg <= 4'h0;
        sda_oe_o <= 1'b0;
      end
      else if (stop_det)
      begin
        sda_oe_o <= 1'b0;
        if (write_mode_reg && (|mask_reg))
        begin
          state_reg <= ST_COMMIT;
          commit_idx_reg <= {`EEB_PAGE_IDX_W{1'b0}};
          write_busy_o <= 1'b1;
          write_mode_reg <= 1'b0;
        end
        else
          state_reg <= ST_IDLE;
      end
      else
      begin
        case (state_reg)
          ST_RX:
          begin
            if (scl_rise && (bit_cnt_reg != BYTE_BITS))
            begin
              rx_shift_reg <= {rx_shift_reg[6:0], sda_f};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
            else if (byte_done)
            begin
              bit_cnt_reg <= 4'h0;
              case (kind_reg)
                KIND_SLAVE:
                begin
                  // All eight block codes belong to this device
                  if (type_field == TYPE_CODE)
                  begin
                    sda_oe_o <= 1'b1;
                    state_reg <= ST_ACK;
                    rw_reg <= rw_bit;
                    blk_reg <= {block_select_bit2, block_select_bit1, block_select_bit0};
                    // Block select replaces the upper address bits for reads too
                    addr_reg[`EEB_ADDR_W-1:`EEB_BITS_PER_BYTE] <=
                      {block_select_bit2, block_select_bit1, block_select_bit0};
                    write_mode_reg <= ~rw_bit;
                    if (!rw_bit)
                      mask_reg <= {`EEB_PAGE_BYTES{1'b0}};
                  end
                  else
                    state_reg <= ST_WAIT;
                end
                KIND_ADDR:
                begin
                  addr_reg <= {blk_reg, rx_shift_reg};
                  page_base_reg <= {blk_reg, rx_shift_reg[7:`EEB_PAGE_IDX_W]};
                  sda_oe_o <= 1'b1;
                  state_reg <= ST_ACK;
                end
                default:
                begin
                  // Address wraps inside the 16-byte page
                  mask_reg[page_idx] <= 1'b1;
                  addr_reg[`EEB_PAGE_IDX_W-1:0] <= page_idx + 1'b1;
                  sda_oe_o <= 1'b1;
                  state_reg <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg)
              begin
                // Read data already sits at the memory output
                tx_shift_reg <= mem_rdata;
                sda_oe_o <= ~mem_rdata[7];
                addr_reg <= addr_reg + 1'b1;
                state_reg <= ST_TX;
              end
              else
              begin
                sda_oe_o <= 1'b0;
                kind_reg <= (kind_reg == KIND_SLAVE) ? KIND_ADDR : KIND_DATA;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX:
          begin
            if (scl_rise)
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            else if (scl_fall)
            begin
              if (bit_cnt_reg == BYTE_BITS)
              begin
                sda_oe_o <= 1'b0;
                state_reg <= ST_RACK;
              end
              else
              begin
                sda_oe_o <= ~tx_shift_reg[6];
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise && sda_f)
              state_reg <= ST_WAIT;
            else if (scl_fall)
            begin
              tx_shift_reg <= mem_rdata;
              sda_oe_o <= ~mem_rdata[7];
              addr_reg <= addr_reg + 1'b1;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_TX;
            end
          end
          default:
          begin
            // Idle and wait: data line released until a start or stop
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

/* File: rtl/eeb_consts.vh */
// Constants for the two-wire serial EEPROM slave front end.
// Assumes a 100 MHz system clock; all counts derive from it.
`ifndef EEB_CONSTS_VH
`define EEB_CONSTS_VH

`define EEB_CLK_MHZ 100

// Input noise suppression, least pulse width kept (ns), rounded up to cycles
`define EEB_NOISE_STD_NS 100
`define EEB_NOISE_FAST_NS 50
`define EEB_NOISE_STD_CYC ((`EEB_NOISE_STD_NS * `EEB_CLK_MHZ + 999) / 1000)
`define EEB_NOISE_FAST_CYC ((`EEB_NOISE_FAST_NS * `EEB_CLK_MHZ + 999) / 1000)

// Self-timed write cycle, longest time (ms), rounded down to cycles
`define EEB_TWR_HI_MS 10
`define EEB_TWR_LO_MS 15
`define EEB_TWR_HI_CYC (`EEB_TWR_HI_MS * `EEB_CLK_MHZ * 1000)
`define EEB_TWR_LO_CYC (`EEB_TWR_LO_MS * `EEB_CLK_MHZ * 1000)
`define EEB_TWR_CNT_W 24

// Slave address fields
`define EEB_SA_RW_BIT 0
`define EEB_SA_BLK_LSB 1
`define EEB_SA_BLK_MSB 3
`define EEB_SA_TYPE_LSB 4
`define EEB_SA_TYPE_MSB 7

// Array organisation
`define EEB_BITS_PER_BYTE 8
`define EEB_ADDR_W 11
`define EEB_PAGE_IDX_W 4
`define EEB_PAGE_BYTES 16

`endif

/* File: rtl/eeb_pin_filter.v */
// Two-flop synchroniser plus noise filter for one bus pin.
// Assumes the pin is asynchronous to mclk_i and idles high (pulled up).
`timescale 1ns/1ns

module eeb_pin_filter #(
  parameter STABLE_CYCLES = 10,
  parameter CW = 8
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire pin_i,
  output reg level_o
);

  reg sync1_reg;
  reg sync2_reg;
  reg [CW-1:0] cnt_reg;
  localparam integer CNT_LAST_I = STABLE_CYCLES - 1;
  localparam [CW-1:0] CNT_LAST = CNT_LAST_I[CW-1:0];

  // A new level is taken only after it held for STABLE_CYCLES samples
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      cnt_reg <= {CW{1'b0}};
      level_o <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      if (sync2_reg == level_o)
        cnt_reg <= {CW{1'b0}};
      else if (cnt_reg == CNT_LAST)
      begin
        level_o <= sync2_reg;
        cnt_reg <= {CW{1'b0}};
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

/* File: rtl/eeb_mem.v */
// Byte-wide storage array with one write port and a registered read port.
// Assumes a single clock; read data follow the read address one cycle later.
`timescale 1ns/1ns

module eeb_mem #(
  parameter AW = 11,
  parameter DW = 8
) (
  input wire mclk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
    rdata_o <= mem[raddr_i];
  end

endmodule

/* File: testbench/eeb_slave_monitor.sv */
// Checker for the two-wire EEPROM slave, watching only its top ports.
// Assumes bus clock phases far longer than the pin filter delay.
`timescale 1ns/1ns
module eeb_slave_monitor #(
  parameter TWR_CYCLES = 2000
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire write_busy_o
);
  reg [23:0] busy_cnt_reg;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      busy_cnt_reg <= 24'h0;
    else
      busy_cnt_reg <= write_busy_o ? busy_cnt_reg + 24'h1 : 24'h0;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  a_drive_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data drive not low");
  a_busy_silent: assert property (write_busy_o |-> !sda_oe_o)
    else $error("data driven while busy");
  a_busy_after_stop: assert property ($rose(write_busy_o) |-> scl_i && sda_i)
    else $error("busy without idle bus");
  a_busy_hold: assert property ($rose(write_busy_o) |-> write_busy_o [*8])
    else $error("busy too short");
  // Commit adds a few cycles beyond the timed part
  a_busy_max: assert property (busy_cnt_reg <= TWR_CYCLES + 20)
    else $error("busy too long");
  a_busy_min: assert property ($fell(write_busy_o) |-> busy_cnt_reg >= TWR_CYCLES)
    else $error("busy ended early");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed with clock high");
  a_ack_width: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("drive pulse too short");
  c_busy: cover property ($fell(write_busy_o));
  c_drive: cover property ($rose(sda_oe_o));
  c_stop: cover property (scl_i && $rose(sda_i));
endmodule
bind eeb_slave eeb_slave_monitor #(.TWR_CYCLES(TWR_CYCLES)) u_mon (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .write_busy_o(write_busy_o)
);

/* File: testbench/eeb_bus_master.sv */
// Behavioural two-wire bus master, stepping in quarter bus periods.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
module eeb_bus_master #(
  parameter QTR = 25
) (
  input wire mclk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_oe_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Slow enough that the slave's filtered answer settles well before the rise
  task quarter;
    repeat (QTR) @(posedge mclk_i);
  endtask
  task bus_start;
    begin
      sda_oe_o <= 1'b0;
      quarter;
      scl_o <= 1'b1;
      quarter;
      sda_oe_o <= 1'b1;
      quarter;
      scl_o <= 1'b0;
      quarter;
    end
  endtask
  task bus_stop;
    begin
      sda_oe_o <= 1'b1;
      quarter;
      scl_o <= 1'b1;
      quarter;
      sda_oe_o <= 1'b0;
      repeat (4) quarter;
    end
  endtask
  task bit_io(input b, output r);
    begin
      sda_oe_o <= ~b;
      quarter;
      scl_o <= 1'b1;
      quarter;
      r = sda_i;
      quarter;
      scl_o <= 1'b0;
      quarter;
    end
  endtask
  // Released data bits (1) let the slave drive; ninth bit is the acknowledge
  task xfer(input [7:0] d, input mack, output [7:0] r, output ackd);
    integer i;
    reg a;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        bit_io(d[i], a);
        r[i] = a;
      end
      bit_io(~mack, a);
      ackd = ~a;
    end
  endtask
endmodule

/* File: testbench/test_serial_eeprom_bus_addressing.sv */
// Self-checking bench for the two-wire EEPROM slave front end.
// Assumes a shortened write cycle via TWR_CYCLES.
`timescale 1ns/1ns
module test_serial_eeprom_bus_addressing;
  localparam TWR = 2000;
  // Arbitrary type code, same as the design default
  localparam [3:0] TC = 4'h6;
  // Arbitrary type code of the fast-grade twin
  localparam [3:0] FC = 4'h9;
  reg mclk;
  reg rst_n;
  wire scl;
  wire m_oe;
  wire sda_o;
  wire sda_oe;
  wire busy;
  wire f_so;
  wire f_oe;
  wire f_busy;
  wire sda_w;
  integer err_count;
  integer checks_done;
  integer cyc;
  integer k;
  reg [7:0] rd;
  reg ak;
  assign sda_w = ~(m_oe | (sda_oe & ~sda_o) | (f_oe & ~f_so));
  eeb_slave #(.FAST_GRADE(0), .LOW_SUPPLY(0), .TWR_CYCLES(TWR), .TYPE_CODE(TC)) u_dut (
    .mclk_i(mclk),
    .rst_n_i(rst_n),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe),
    .write_busy_o(busy)
  );
  // Fast-grade twin on the same wires, so the short noise filter is exercised too
  eeb_slave #(.FAST_GRADE(1), .LOW_SUPPLY(1), .TWR_CYCLES(TWR), .TYPE_CODE(FC)) u_dut_fast (
    .mclk_i(mclk),
    .rst_n_i(rst_n),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(f_so),
    .sda_oe_o(f_oe),
    .write_busy_o(f_busy)
  );
  eeb_bus_master #(.QTR(25)) u_m (
    .mclk_i(mclk),
    .sda_i(sda_w),
    .scl_o(scl),
    .sda_oe_o(m_oe)
  );
  ////////////////////////////////////////////////////////////////////////
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task sel(input [2:0] b, input rw, input [3:0] t);
    begin
      u_m.bus_start;
      u_m.xfer({t, b, rw}, 1'b0, rd, ak);
    end
  endtask
  task point(input [2:0] b, input [7:0] a);
    begin
      sel(b, 1'b0, TC);
      check({7'h0, ak}, 8'h01);
      u_m.xfer(a, 1'b0, rd, ak);
      check({7'h0, ak}, 8'h01);
    end
  endtask
  task wait_idle;
    begin
      for (k = 0; k < 3000 && busy !== 1'b0; k = k + 1)
        @(posedge mclk);
      check({7'h0, busy}, 8'h00);
    end
  endtask
  task rd1(input [2:0] b, input [7:0] a, input [7:0] exp);
    begin
      point(b, a);
      sel(b, 1'b1, TC);
      check({7'h0, ak}, 8'h01);
      u_m.xfer(8'hff, 1'b0, rd, ak);
      check(rd, exp);
      u_m.bus_stop;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_select;
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        sel(k[2:0], 1'b0, TC);
        check({7'h0, ak}, 8'h01);
        u_m.bus_stop;
      end
      sel(3'd0, 1'b0, TC ^ 4'h8);
      check({7'h0, ak}, 8'h00);
      u_m.bus_stop;
      $display("t_select done");
    end
  endtask
  task t_page;
    begin
      point(3'd5, 8'h3e);
      for (k = 1; k < 4; k = k + 1)
      begin
        u_m.xfer(8'ha0 + k[7:0], 1'b0, rd, ak);
        check({7'h0, ak}, 8'h01);
      end
      u_m.bus_stop;
      check({7'h0, busy}, 8'h01);
      sel(3'd5, 1'b1, TC);
      check({7'h0, ak}, 8'h00);
      u_m.bus_stop;
      wait_idle;
      // Third byte wrapped to the start of the 16-byte page
      rd1(3'd5, 8'h30, 8'ha3);
      $display("t_page done");
    end
  endtask
  task t_read;
    begin
      point(3'd5, 8'h3e);
      sel(3'd5, 1'b1, TC);
      check({7'h0, ak}, 8'h01);
      u_m.xfer(8'hff, 1'b1, rd, ak);
      check(rd, 8'ha1);
      u_m.xfer(8'hff, 1'b0, rd, ak);
      check(rd, 8'ha2);
      // After the missing acknowledge the slave must leave the line alone
      u_m.xfer(8'hff, 1'b0, rd, ak);
      check(rd, 8'hff);
      u_m.bus_stop;
      $display("t_read done");
    end
  endtask
  task t_blocks;
    begin
      point(3'd2, 8'h3e);
      u_m.xfer(8'h5c, 1'b0, rd, ak);
      check({7'h0, ak}, 8'h01);
      u_m.bus_stop;
      wait_idle;
      rd1(3'd5, 8'h3e, 8'ha1);
      rd1(3'd2, 8'h3e, 8'h5c);
      $display("t_blocks done");
    end
  endtask
  task t_fast;
    begin
      sel(3'd3, 1'b0, FC);
      check({7'h0, ak}, 8'h01);
      u_m.xfer(8'h47, 1'b0, rd, ak);
      check({7'h0, ak}, 8'h01);
      u_m.xfer(8'h9b, 1'b0, rd, ak);
      check({7'h0, ak}, 8'h01);
      u_m.bus_stop;
      check({7'h0, f_busy}, 8'h01);
      for (k = 0; k < 3000 && f_busy !== 1'b0; k = k + 1)
        @(posedge mclk);
      check({7'h0, f_busy}, 8'h00);
      sel(3'd3, 1'b0, FC);
      u_m.xfer(8'h47, 1'b0, rd, ak);
      check({7'h0, ak}, 8'h01);
      sel(3'd3, 1'b1, FC);
      check({7'h0, ak}, 8'h01);
      u_m.xfer(8'hff, 1'b0, rd, ak);
      check(rd, 8'h9b);
      u_m.bus_stop;
      $display("t_fast done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  initial
  begin
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (20) @(posedge mclk);
    t_select;
    t_page;
    t_read;
    t_blocks;
    t_fast;
    complete_run;
  end
endmodule
